// [cnmt_pkg.sv]
// Constants and types shared by the network-management node logic.
package cnmt_pkg;

   // Identifier bases; the node ID is added to the low seven bits.
   localparam logic [10:0] COB_NMT = 11'h000;
   localparam logic [10:0] EMCY_BASE = 11'h080;
   localparam logic [10:0] SDO_TX_BASE = 11'h580;
   localparam logic [10:0] SDO_RX_BASE = 11'h600;
   localparam logic [10:0] HB_BASE = 11'h700;

   // Reported state codes.
   localparam logic [7:0] CODE_INIT = 8'h00;
   localparam logic [7:0] CODE_PREOP = 8'h7f;
   localparam logic [7:0] CODE_OPER = 8'h05;
   localparam logic [7:0] CODE_STOP = 8'h04;

   // Command specifiers carried in the first byte of a node-control frame.
   localparam logic [7:0] CS_START = 8'h01;
   localparam logic [7:0] CS_STOP = 8'h02;
   localparam logic [7:0] CS_PREOP = 8'h80;
   localparam logic [7:0] CS_RST_NODE = 8'h81;
   localparam logic [7:0] CS_RST_COMM = 8'h82;

   // Values accepted on the local state write port.
   localparam logic [7:0] LOC_PREOP = 8'h7f;
   localparam logic [7:0] LOC_RST_NODE = 8'h80;
   localparam logic [7:0] LOC_RST_COMM = 8'h81;

   // Frame lengths and contents.
   localparam logic [3:0] NMT_DLC = 4'h2;
   localparam logic [3:0] BOOT_DLC = 4'h1;
   localparam logic [3:0] EMCY_DLC = 4'h8;
   localparam logic [7:0] BOOT_DATA = 8'h00;
   localparam logic [7:0] NODE_ALL = 8'h00;

   // Network-management states.
   typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_OPER, ST_STOP} cnmt_state_t;

endpackage : cnmt_pkg

// [cnmt_rx_decode.sv]
// Classifies a received frame as node control, service-data request or other traffic.
module cnmt_rx_decode (
   input wire logic [10:0] rx_id,
   input wire logic [3:0] rx_dlc,
   input wire logic [7:0] rx_data1,
   input wire logic [6:0] node_id,
   output logic nmt_hit,
   output logic sdo_hit,
   output logic other_hit
);

   logic addressed;

   assign addressed = (rx_data1 == cnmt_pkg::NODE_ALL) || (rx_data1 == {1'b0, node_id});

   assign nmt_hit = (rx_id == cnmt_pkg::COB_NMT) && (rx_dlc == cnmt_pkg::NMT_DLC) && addressed;

   assign sdo_hit = rx_id == (cnmt_pkg::SDO_RX_BASE | {4'h0, node_id});

   // Anything else not on the node-control identifier is process-data candidate traffic.
   assign other_hit = (rx_id != cnmt_pkg::COB_NMT) && !sdo_hit;

endmodule : cnmt_rx_decode

// [cnmt_tx_arb.sv]
// Chooses between two pending transmit requests by identifier value.
module cnmt_tx_arb (
   input wire logic req_a,
   input wire logic [10:0] id_a,
   input wire logic req_b,
   input wire logic [10:0] id_b,
   output logic grant,
   output logic pick_b,
   output logic [10:0] id
);

   assign pick_b = req_b && (!req_a || (id_b < id_a));
   assign grant = req_a || req_b;
   assign id = pick_b ? id_b : id_a;

endmodule : cnmt_tx_arb

// [cnmt_node.sv]
// Network-management state machine, identifier assignment and traffic gating of a node.

//Contract
// - Each object has a unique 11-bit identifier.
// - Numerically smallest identifier has priority and is sent first.
// - Node-control commands use fixed identifier zero.
// - Service-data responses on 0x580+node, requests on 0x600+node.
// - Emergency identifier defaults to 0x80+node and is configurable.
// - Boot-up frame on 0x700+node with one zero byte.
// - Power-up selection picks Stopped 4, Operational 5, Pre-Operational 127.
// - State reported as code: 0, 127, 5, 4.
// - Decode Start 1, Stop 2, Pre-Op 128, Reset Node 129, Reset Comm 130.
// - Local writes 127, 128, 129 act like the bus commands.
// - Pre-Operational blocks process data, serves service data.
// - Operational allows service data and process data.
// - Stopped ignores service and process data, obeys node control.
// - Invalid command specifier sends the node to Stopped.
// - Act on commands addressed to own ID or to zero.
// - Start moves Pre-Operational to Operational.
// - Stop moves Pre-Operational or Operational to Stopped.
// - Enter Pre-Operational from Operational or Stopped.
// - Reset Node goes to Initialization restoring all objects.
// - Reset Communication goes to Initialization restoring communication objects.
module cnmt_node (
   input wire logic clock,
   input wire logic rst,
   input wire logic [6:0] node_id,
   input wire logic [7:0] power_up_state_select,
   input wire logic local_state_wr,
   input wire logic [7:0] local_state_value,
   input wire logic emcy_id_wr,
   input wire logic [10:0] emcy_id_wdata,
   input wire logic emcy_req,
   input wire logic rx_valid,
   input wire logic [10:0] rx_id,
   input wire logic [3:0] rx_dlc,
   input wire logic [7:0] rx_data0,
   input wire logic [7:0] rx_data1,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [10:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic [7:0] tx_data0,
   output logic [7:0] nmt_state_value,
   output logic sdo_enable,
   output logic pdo_enable,
   output logic sdo_req_valid,
   output logic pdo_rx_valid,
   output logic [10:0] sdo_rx_id,
   output logic [10:0] sdo_tx_id,
   output logic [10:0] emcy_id,
   output logic [10:0] hb_id,
   output logic app_restore,
   output logic comm_restore
);

   typedef struct packed {
      cnmt_pkg::cnmt_state_t state;
      logic [6:0] node_id;
      logic boot_pend;
      logic emcy_pend;
      logic tx_valid;
      logic tx_boot;
      logic [10:0] tx_id;
      logic [3:0] tx_dlc;
      logic [7:0] tx_data0;
      logic [7:0] nmt_state_value;
      logic sdo_enable;
      logic pdo_enable;
      logic sdo_req_valid;
      logic pdo_rx_valid;
      logic [10:0] sdo_rx_id;
      logic [10:0] sdo_tx_id;
      logic [10:0] emcy_id;
      logic [10:0] hb_id;
      logic app_restore;
      logic comm_restore;
   } cnmt_regs_t;

   cnmt_regs_t s;
   cnmt_regs_t next_s;

   logic dec_nmt;
   logic dec_sdo;
   logic dec_other;
   logic arb_grant;
   logic arb_pick_emcy;
   logic [10:0] arb_id;
   logic [6:0] live_node;
   logic live;
   logic cmd_ok;
   logic boot_done;

   // In Initialization the node ID is read fresh from the port, otherwise the latched copy.
   assign live_node = (s.state == cnmt_pkg::ST_INIT) ? node_id : s.node_id;
   assign live = (s.state == cnmt_pkg::ST_PREOP) || (s.state == cnmt_pkg::ST_OPER);
   assign cmd_ok = rx_valid && dec_nmt && (s.state != cnmt_pkg::ST_INIT);
   assign boot_done = s.tx_valid && tx_ready && s.tx_boot;

   cnmt_rx_decode u_dec (
      .rx_id(rx_id),
      .rx_dlc(rx_dlc),
      .rx_data1(rx_data1),
      .node_id(live_node),
      .nmt_hit(dec_nmt),
      .sdo_hit(dec_sdo),
      .other_hit(dec_other)
   );

   // Emergency frames compete only while the node may talk on the bus.
   cnmt_tx_arb u_arb (
      .req_a(s.boot_pend),
      .id_a(cnmt_pkg::HB_BASE | {4'h0, live_node}),
      .req_b(s.emcy_pend && live),
      .id_b(s.emcy_id),
      .grant(arb_grant),
      .pick_b(arb_pick_emcy),
      .id(arb_id)
   );

   // Maps a power-up selection to the state entered after boot-up.
   function automatic cnmt_pkg::cnmt_state_t power_up_target(input logic [7:0] sel);
      cnmt_pkg::cnmt_state_t t;
      t = cnmt_pkg::ST_PREOP;
      if (sel == cnmt_pkg::CODE_STOP) begin
         t = cnmt_pkg::ST_STOP;
      end else if (sel == cnmt_pkg::CODE_OPER) begin
         t = cnmt_pkg::ST_OPER;
      end
      return t;
   endfunction : power_up_target

   // Maps a state to its reported code.
   function automatic logic [7:0] state_code(input cnmt_pkg::cnmt_state_t st);
      logic [7:0] c;
      c = cnmt_pkg::CODE_INIT;
      unique case (st)
         cnmt_pkg::ST_INIT: c = cnmt_pkg::CODE_INIT;
         cnmt_pkg::ST_PREOP: c = cnmt_pkg::CODE_PREOP;
         cnmt_pkg::ST_OPER: c = cnmt_pkg::CODE_OPER;
         cnmt_pkg::ST_STOP: c = cnmt_pkg::CODE_STOP;
      endcase
      return c;
   endfunction : state_code

   // Computes the whole next state of the node.
   always_comb begin
      logic go_init;
      logic node_rst;
      go_init = 1'b0;
      node_rst = 1'b0;
      next_s = s;
      next_s.app_restore = 1'b0;
      next_s.comm_restore = 1'b0;
      next_s.sdo_req_valid = 1'b0;
      next_s.pdo_rx_valid = 1'b0;

      // Transmit slot: retire on acceptance, then reload from the arbiter.
      if (s.tx_valid && tx_ready) begin
         next_s.tx_valid = 1'b0;
      end
      if (!next_s.tx_valid && arb_grant) begin
         next_s.tx_valid = 1'b1;
         next_s.tx_id = arb_id;
         next_s.tx_boot = !arb_pick_emcy;
         if (arb_pick_emcy) begin
            next_s.emcy_pend = 1'b0;
            next_s.tx_dlc = cnmt_pkg::EMCY_DLC;
            next_s.tx_data0 = cnmt_pkg::BOOT_DATA;
         end else begin
            next_s.boot_pend = 1'b0;
            next_s.tx_dlc = cnmt_pkg::BOOT_DLC;
            next_s.tx_data0 = cnmt_pkg::BOOT_DATA;
         end
      end
      // A new emergency request wins over the clear of the same cycle.
      if (emcy_req && live) begin
         next_s.emcy_pend = 1'b1;
      end

      unique case (s.state)
         cnmt_pkg::ST_INIT: begin
            next_s.node_id = node_id;
            next_s.sdo_tx_id = cnmt_pkg::SDO_TX_BASE | {4'h0, node_id};
            next_s.sdo_rx_id = cnmt_pkg::SDO_RX_BASE | {4'h0, node_id};
            next_s.emcy_id = cnmt_pkg::EMCY_BASE | {4'h0, node_id};
            next_s.hb_id = cnmt_pkg::HB_BASE | {4'h0, node_id};
            if (boot_done) begin
               next_s.state = power_up_target(power_up_state_select);
            end
         end
         default: begin
            if (emcy_id_wr) begin
               next_s.emcy_id = emcy_id_wdata;
            end
            if (cmd_ok) begin
               if (rx_data0 == cnmt_pkg::CS_START) begin
                  if (s.state != cnmt_pkg::ST_OPER) begin
                     next_s.state = cnmt_pkg::ST_OPER;
                  end
               end else if (rx_data0 == cnmt_pkg::CS_STOP) begin
                  next_s.state = cnmt_pkg::ST_STOP;
               end else if (rx_data0 == cnmt_pkg::CS_PREOP) begin
                  next_s.state = cnmt_pkg::ST_PREOP;
               end else if (rx_data0 == cnmt_pkg::CS_RST_NODE) begin
                  go_init = 1'b1;
                  node_rst = 1'b1;
               end else if (rx_data0 == cnmt_pkg::CS_RST_COMM) begin
                  go_init = 1'b1;
               end else begin
                  next_s.state = cnmt_pkg::ST_STOP;
               end
            end else if (local_state_wr) begin
               if (local_state_value == cnmt_pkg::LOC_PREOP) begin
                  next_s.state = cnmt_pkg::ST_PREOP;
               end else if (local_state_value == cnmt_pkg::LOC_RST_NODE) begin
                  go_init = 1'b1;
                  node_rst = 1'b1;
               end else if (local_state_value == cnmt_pkg::LOC_RST_COMM) begin
                  go_init = 1'b1;
               end
            end
         end
      endcase

      if (go_init) begin
         next_s.state = cnmt_pkg::ST_INIT;
         next_s.comm_restore = 1'b1;
         next_s.app_restore = node_rst;
         next_s.boot_pend = 1'b1;
         next_s.emcy_pend = 1'b0;
      end

      // Traffic gating follows the state the frame arrived in.
      // service data in Pre-Operational and Operational
      next_s.sdo_req_valid = rx_valid && dec_sdo && live;
      next_s.pdo_rx_valid = rx_valid && dec_other && (s.state == cnmt_pkg::ST_OPER);

      // Level outputs reflect the state being entered.
      next_s.nmt_state_value = state_code(next_s.state);
      next_s.sdo_enable = (next_s.state == cnmt_pkg::ST_PREOP) ||
         (next_s.state == cnmt_pkg::ST_OPER);
      next_s.pdo_enable = next_s.state == cnmt_pkg::ST_OPER;
   end

   // Registers the whole state; reset starts in Initialization with a boot-up pending.
   always_ff @(posedge clock) begin
      if (rst) begin
         s <= '0;
         s.boot_pend <= 1'b1;
         s.nmt_state_value <= cnmt_pkg::CODE_INIT;
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from the state register.
   assign tx_valid = s.tx_valid;
   assign tx_id = s.tx_id;
   assign tx_dlc = s.tx_dlc;
   assign tx_data0 = s.tx_data0;
   assign nmt_state_value = s.nmt_state_value;
   assign sdo_enable = s.sdo_enable;
   assign pdo_enable = s.pdo_enable;
   assign sdo_req_valid = s.sdo_req_valid;
   assign pdo_rx_valid = s.pdo_rx_valid;
   assign sdo_rx_id = s.sdo_rx_id;
   assign sdo_tx_id = s.sdo_tx_id;
   assign emcy_id = s.emcy_id;
   assign hb_id = s.hb_id;
   assign app_restore = s.app_restore;
   assign comm_restore = s.comm_restore;

   // Checks on the state machine and the traffic gates.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence reset_node_cmd_s;
      cmd_ok && (rx_data0 == cnmt_pkg::CS_RST_NODE);
   endsequence

   sequence reset_node_effect_s;
      app_restore && comm_restore && (s.state == cnmt_pkg::ST_INIT) && s.boot_pend;
   endsequence

   sequence start_cmd_s;
      cmd_ok && (rx_data0 == cnmt_pkg::CS_START) && (s.state == cnmt_pkg::ST_PREOP);
   endsequence

   boot_frame_a: assert property (tx_valid && s.tx_boot |-> (tx_id == hb_id) &&
      (tx_dlc == cnmt_pkg::BOOT_DLC) && (tx_data0 == 8'h00))
      else $error("boot-up frame malformed");

   sdo_ids_a: assert property (s.state != cnmt_pkg::ST_INIT |->
      (sdo_rx_id - 11'h600 == hb_id - 11'h700) && (sdo_tx_id - 11'h580 == hb_id - 11'h700))
      else $error("service-data identifiers inconsistent");

   reset_node_a: assert property (reset_node_cmd_s |=> reset_node_effect_s)
      else $error("reset node did not restart node");

   start_cmd_a: assert property (start_cmd_s |=>
      (s.state == cnmt_pkg::ST_OPER) && (nmt_state_value == 8'h05) && pdo_enable)
      else $error("start did not reach operational");

   bad_cmd_a: assert property (cmd_ok && (rx_data0 > 8'h02) && (rx_data0 < 8'h80) |=>
      (s.state == cnmt_pkg::ST_STOP) && (nmt_state_value == 8'h04))
      else $error("invalid command did not stop node");

   stop_gate_a: assert property (s.state == cnmt_pkg::ST_STOP |=>
      !sdo_req_valid && !pdo_rx_valid)
      else $error("traffic passed in stopped state");

   preop_sdo_a: assert property (rx_valid && dec_sdo && (s.state == cnmt_pkg::ST_PREOP) |=>
      sdo_req_valid && !pdo_rx_valid)
      else $error("service request not served in pre-operational");

   pdo_gate_a: assert property (pdo_rx_valid |-> $past(s.state) == cnmt_pkg::ST_OPER)
      else $error("process data outside operational");

   power_up_a: assert property (boot_done && (power_up_state_select == 8'h05) |=>
      (s.state == cnmt_pkg::ST_OPER) ##1 (s.state != cnmt_pkg::ST_INIT))
      else $error("power-up selection ignored");

endmodule : cnmt_node

// [cnmt_mgr_model.sv]
// Behavioural network manager that sends frames to the node and accepts its transmissions.
module cnmt_mgr_model (
   input wire logic clock,
   input wire logic slow,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic rx_valid,
   output logic [10:0] rx_id,
   output logic [3:0] rx_dlc,
   output logic [7:0] rx_data0,
   output logic [7:0] rx_data1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] pace;
   int taken;

   // Idle frame lines carry junk so that stale values are never mistaken for a frame.
   initial begin
      rx_valid = 1'b0;
      rx_id = 11'h7ff;
      rx_dlc = 4'hf;
      rx_data0 = 8'hff;
      rx_data1 = 8'hff;
      tx_ready = 1'b1;
      pace = 2'h0;
      taken = 0;
   end

   // Acceptance is prompt, or one edge in four when slow is set.
   always @(posedge clock) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         taken <= taken + 1;
      end
      #1;
      pace = pace + 2'h1;
      tx_ready = slow ? (pace == 2'h3) : 1'b1;
   end

   // Presents one frame for exactly one edge, then scrambles the lines.
   task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [7:0] d0,
                       input logic [7:0] d1);
      @(posedge clock);
      #1;
      rx_valid = 1'b1;
      rx_id = id;
      rx_dlc = dlc;
      rx_data0 = d0;
      rx_data1 = d1;
      @(posedge clock);
      #1;
      rx_valid = 1'b0;
      rx_id = ~id;
      rx_dlc = ~dlc;
      rx_data0 = ~d0;
      rx_data1 = ~d1;
   endtask : send

   task automatic nmt(input logic [7:0] cs, input logic [7:0] node);
      send(11'h000, 4'h2, cs, node);
   endtask : nmt
endmodule : cnmt_mgr_model

// [cnmt_node_tb_top.sv]
// Self-checking testbench of the network-management node.
module cnmt_node_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] NODE = 7'h2a;
   logic clock, rst, local_state_wr, emcy_id_wr, emcy_req, rx_valid, tx_ready, tx_valid, slow;
   logic [6:0] node_id;
   logic [7:0] power_up_state_select, local_state_value, rx_data0, rx_data1, tx_data0;
   logic [7:0] nmt_state_value;
   logic [10:0] emcy_id_wdata, rx_id, tx_id, sdo_rx_id, sdo_tx_id, emcy_id, hb_id;
   logic [3:0] rx_dlc, tx_dlc;
   logic sdo_enable, pdo_enable, sdo_req_valid, pdo_rx_valid, app_restore, comm_restore;
   int bad_count = 0;
   int check_count = 0;

   cnmt_node uut (.clock(clock), .rst(rst), .node_id(node_id),
      .power_up_state_select(power_up_state_select), .local_state_wr(local_state_wr),
      .local_state_value(local_state_value), .emcy_id_wr(emcy_id_wr),
      .emcy_id_wdata(emcy_id_wdata), .emcy_req(emcy_req), .rx_valid(rx_valid), .rx_id(rx_id),
      .rx_dlc(rx_dlc), .rx_data0(rx_data0), .rx_data1(rx_data1), .tx_ready(tx_ready),
      .tx_valid(tx_valid), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data0(tx_data0),
      .nmt_state_value(nmt_state_value), .sdo_enable(sdo_enable), .pdo_enable(pdo_enable),
      .sdo_req_valid(sdo_req_valid), .pdo_rx_valid(pdo_rx_valid), .sdo_rx_id(sdo_rx_id),
      .sdo_tx_id(sdo_tx_id), .emcy_id(emcy_id), .hb_id(hb_id), .app_restore(app_restore),
      .comm_restore(comm_restore));

   cnmt_mgr_model mgr (.clock(clock), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data0(rx_data0),
      .rx_data1(rx_data1));

   // Free-running 50 MHz clock.
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   // Compares one observed value with its expectation.
   task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
      check_count++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask : chk

   // Waits a bounded time for a reported state code.
   task automatic wait_state(input logic [7:0] code);
      for (int i = 0; i < 40 && nmt_state_value !== code; i++) begin
         @(posedge clock);
         #1;
      end
      chk("state", {3'h0, code}, {3'h0, nmt_state_value});
   endtask : wait_state

   // Waits for the boot-up frame and checks its contents.
   task automatic wait_boot;
      for (int i = 0; i < 20 && tx_valid !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      chk("boot valid", 11'h001, {10'h0, tx_valid});
      chk("boot id", 11'h700 + NODE, tx_id);
      chk("boot dlc", 11'h001, {7'h0, tx_dlc});
      chk("boot data", 11'h000, {3'h0, tx_data0});
      chk("init code", 11'h000, {3'h0, nmt_state_value});
   endtask : wait_boot

   // Writes the local state setting for one cycle.
   task automatic local_wr(input logic [7:0] v);
      @(posedge clock);
      #1;
      local_state_wr = 1'b1;
      local_state_value = v;
      @(posedge clock);
      #1;
      local_state_wr = 1'b0;
   endtask : local_wr

   // Sends a service-data request and a process-data frame and checks both pulses.
   task automatic traffic(input logic sdo_exp, input logic pdo_exp);
      mgr.send(11'h600 + NODE, 4'h8, 8'h40, 8'h00);
      chk("sdo pulse", {10'h0, sdo_exp}, {10'h0, sdo_req_valid});
      mgr.send(11'h200 + NODE, 4'h2, 8'h11, 8'h22);
      chk("pdo pulse", {10'h0, pdo_exp}, {10'h0, pdo_rx_valid});
   endtask : traffic

   // Identifiers are loaded at the first edge after reset, together with the boot-up frame.
   task automatic t_boot;
      wait_boot;
      chk("sdo rx id", 11'h600 + NODE, sdo_rx_id);
      chk("sdo tx id", 11'h580 + NODE, sdo_tx_id);
      chk("emcy id", 11'h080 + NODE, emcy_id);
      chk("hb id", 11'h700 + NODE, hb_id);
      wait_state(8'h7f);
   endtask : t_boot

   task automatic t_cmds;
      mgr.nmt(8'h01, {1'b0, NODE});
      chk("oper", 11'h005, {3'h0, nmt_state_value});
      chk("pdo en", 11'h001, {10'h0, pdo_enable});
      chk("sdo en oper", 11'h001, {10'h0, sdo_enable});
      traffic(1'b1, 1'b1);
      mgr.nmt(8'h02, 8'h00);
      chk("stop", 11'h004, {3'h0, nmt_state_value});
      chk("sdo en stop", 11'h000, {10'h0, sdo_enable});
      chk("pdo en stop", 11'h000, {10'h0, pdo_enable});
      traffic(1'b0, 1'b0);
      mgr.nmt(8'h80, {1'b0, NODE});
      chk("preop", 11'h07f, {3'h0, nmt_state_value});
      chk("sdo en preop", 11'h001, {10'h0, sdo_enable});
      traffic(1'b1, 1'b0);
   endtask : t_cmds

   task automatic t_addr;
      mgr.nmt(8'h01, {1'b0, NODE + 7'h1});
      chk("other node", 11'h07f, {3'h0, nmt_state_value});
      mgr.send(11'h000, 4'h3, 8'h01, {1'b0, NODE});
      chk("bad length", 11'h07f, {3'h0, nmt_state_value});
      mgr.nmt(8'h03, {1'b0, NODE});
      chk("bad cs", 11'h004, {3'h0, nmt_state_value});
   endtask : t_addr

   task automatic t_local;
      local_wr(8'h7f);
      chk("local preop", 11'h07f, {3'h0, nmt_state_value});
      local_wr(8'h80);
      chk("local node rst", 11'h003, {9'h0, app_restore, comm_restore});
      wait_boot;
      wait_state(8'h7f);
      local_wr(8'h81);
      chk("local comm rst", 11'h001, {9'h0, app_restore, comm_restore});
      wait_boot;
      wait_state(8'h7f);
   endtask : t_local

   task automatic t_emcy;
      int t0;
      slow = 1'b1;
      @(posedge clock);
      #1;
      emcy_id_wr = 1'b1;
      emcy_id_wdata = 11'h0a5;
      @(posedge clock);
      #1;
      emcy_id_wr = 1'b0;
      chk("emcy write", 11'h0a5, emcy_id);
      emcy_req = 1'b1;
      @(posedge clock);
      #1;
      emcy_req = 1'b0;
      for (int i = 0; i < 10 && tx_valid !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      chk("emcy tx id", 11'h0a5, tx_id);
      chk("emcy dlc", 11'h008, {7'h0, tx_dlc});
      t0 = mgr.taken;
      for (int i = 0; i < 10 && mgr.taken == t0; i++) begin
         chk("emcy held", 11'h001, {10'h0, tx_valid});
         @(posedge clock);
         #1;
      end
      chk("emcy done", 11'h000, {10'h0, tx_valid});
      slow = 1'b0;
   endtask : t_emcy

   task automatic t_bus_reset;
      power_up_state_select = 8'h05;
      mgr.nmt(8'h81, {1'b0, NODE});
      chk("node rst", 11'h003, {9'h0, app_restore, comm_restore});
      chk("node rst code", 11'h000, {3'h0, nmt_state_value});
      // The default emergency identifier is reloaded in the first Initialization cycle.
      wait_boot;
      chk("emcy default", 11'h080 + NODE, emcy_id);
      wait_state(8'h05);
      power_up_state_select = 8'h04;
      mgr.nmt(8'h82, 8'h00);
      chk("comm rst", 11'h001, {9'h0, app_restore, comm_restore});
      wait_boot;
      wait_state(8'h04);
   endtask : t_bus_reset

   // Main sequence: reset, then every scenario in turn.
   initial begin
      rst = 1'b1;
      slow = 1'b0;
      node_id = NODE;
      power_up_state_select = 8'h7f;
      local_state_wr = 1'b0;
      local_state_value = 8'h00;
      emcy_id_wr = 1'b0;
      emcy_id_wdata = 11'h000;
      emcy_req = 1'b0;
      repeat (20) @(posedge clock);
      #1;
      rst = 1'b0;
      t_boot;
      t_cmds;
      t_addr;
      t_local;
      t_emcy;
      t_bus_reset;
      end_sim;
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #100000;
      bad_count++;
      end_sim;
   end
endmodule : cnmt_node_tb_top
